//--- hw/capcmp_pkg.sv
// Shared constants and carrier types for the capture/compare/PWM control block
package capcmp_pkg;

	// ----------------------------------------------------------------
	// Register indexes (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_FLAG = 10'h00c;
	localparam logic [9:0] IDX_CTRL1 = 10'h017;
	localparam logic [9:0] IDX_CTRL2 = 10'h01d;
	localparam logic [9:0] IDX_ENABLE = 10'h08c;
	localparam logic [9:0] IDX_CAP1_LO = 10'h020;
	localparam logic [9:0] IDX_CAP1_HI = 10'h021;
	localparam logic [9:0] IDX_CAP2_LO = 10'h022;
	localparam logic [9:0] IDX_CAP2_HI = 10'h023;
	localparam logic [9:0] IDX_DUTY1 = 10'h024;
	localparam logic [9:0] IDX_DUTY2 = 10'h025;
	localparam logic [9:0] IDX_PIN_CTRL = 10'h026;
	localparam logic [9:0] IDX_FLAG2 = 10'h027;
	localparam logic [9:0] IDX_ENABLE2 = 10'h028;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int FLAG1_BIT = 2;
	localparam int FLAG2_BIT = 0;
	localparam int DIR_BIT0 = 0;
	localparam int LATCH_BIT0 = 4;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [1:0] DIR_RESET = 2'h3;
	localparam logic [7:0] REG8_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Mode select codes
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR = 4'h9;
	localparam logic [3:0] MODE_CMP_SWI = 4'ha;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
	localparam logic [3:0] PRESCALE4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE16_LAST = 4'hf;

	typedef struct packed {
		logic [1:0] duty_low;
		logic [3:0] mode_select_field;
	} chan_ctrl_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic err;
	} apb_answer_t;

	function automatic logic is_capture(input logic [3:0] m);
		return m[3:2] == 2'h1;
	endfunction

	function automatic logic is_compare(input logic [3:0] m);
		return m[3:2] == 2'h2;
	endfunction

endpackage

//--- hw/capture_event_unit.sv
// Edge selection and rising-edge prescaler for one capture channel
`timescale 1ns/1ps
module capture_event_unit
	import capcmp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	input wire logic [3:0] mode_i,
	output logic event_o
);
	logic prev_level;
	logic [3:0] prev_mode;
	logic [3:0] pre_cnt;
	logic rise;
	logic fall;

	assign rise = level_i & ~prev_level;
	assign fall = ~level_i & prev_level;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prev_level <= 1'b0;
			prev_mode <= 4'h0;
		end
		else
		begin
			prev_level <= level_i;
			prev_mode <= mode_i;
		end
	end

	// ----------------------------------------------------------------
	// Prescaler, cleared when switched off or the event changes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pre_cnt <= 4'h0;
		else if (mode_i == MODE_OFF || mode_i != prev_mode)
			pre_cnt <= 4'h0;
		else if (rise)
			pre_cnt <= pre_cnt + 4'h1;
	end

	always_comb
	begin
		unique case (mode_i)
			MODE_CAP_FALL: event_o = fall;
			MODE_CAP_RISE: event_o = rise;
			MODE_CAP_RISE4: event_o = rise && pre_cnt[1:0] == PRESCALE4_LAST[1:0];
			MODE_CAP_RISE16: event_o = rise && pre_cnt == PRESCALE16_LAST;
			default: event_o = 1'b0;
		endcase
	end

endmodule // capture_event_unit

//--- hw/capcmp_ctrl.sv
// Capture/compare/PWM control: APB registers, capture, compare events, IRQ
//
// Overview of operation
// - Control register bits 7 and 6 always read back as zero.
// - In PWM mode control bits 5:4 are the low two duty bits.
// - A capture copies the full 16-bit timer count into the pair.
// - Modes 0100/0101/0110/0111 capture on fall/rise/4th/16th rise.
// - Each capture sets the request flag until software clears it.
// - A new capture overwrites the pair even if it was not read.
// - With the pin an output, a latch level change is a capture edge.
// - A capture event change while active may set the flag falsely.
// - Compare mode 1010 sets the flag on a match, pin untouched.
// - Compare mode 1011 sets the flag on a match and resets the timer.
`timescale 1ns/1ps
module capcmp_ctrl
	import capcmp_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic [15:0] TIMER_I,
	input wire logic [1:0] CAP_PIN_I,
	output logic [1:0] CAP_PIN_O,
	output logic [1:0] CAP_PIN_OE_O,
	output logic TIMER_RESET_O,
	output logic [9:0] DUTY1_O,
	output logic [9:0] DUTY2_O,
	output logic IRQ_O
);
	import capcmp_pkg::*;

	chan_ctrl_t ctrl [2];
	logic [15:0] cap [2];
	logic [7:0] duty_hi [2];
	logic [1:0] dir;
	logic [1:0] latch_a;
	logic [1:0] flag;
	logic [1:0] enable;
	logic [1:0] s1, s2, s3;
	logic [1:0] pin_lvl;
	logic [1:0] eff_lvl;
	logic [1:0] cap_evt;
	logic [1:0] match_q;
	logic [1:0] cmp_hit;
	logic [1:0] false_evt;
	logic [1:0] cmp_lvl;
	logic [1:0] flag_clr;
	logic wr;
	logic setup;
	logic [9:0] idx;
	apb_answer_t next_answer;

	assign idx = PADDR_I[11:2];
	assign wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign setup = PSEL_I & ~PENABLE_I;
	assign PREADY_O = 1'b1;

	// ----------------------------------------------------------------
	// Read decode, registered in the setup phase
	// ----------------------------------------------------------------
	function automatic logic [7:0] ctrl_byte(input chan_ctrl_t c);
		return {2'h0, c};
	endfunction

	always_comb
	begin
		next_answer = '{rdata: 32'h0000_0000, err: 1'b0};
		unique case (idx)
			IDX_FLAG: next_answer.rdata[FLAG1_BIT] = flag[0];
			IDX_ENABLE: next_answer.rdata[FLAG1_BIT] = enable[0];
			IDX_FLAG2: next_answer.rdata[FLAG2_BIT] = flag[1];
			IDX_ENABLE2: next_answer.rdata[FLAG2_BIT] = enable[1];
			IDX_CTRL1: next_answer.rdata[7:0] = ctrl_byte(ctrl[0]);
			IDX_CTRL2: next_answer.rdata[7:0] = ctrl_byte(ctrl[1]);
			IDX_CAP1_LO: next_answer.rdata[7:0] = cap[0][7:0];
			IDX_CAP1_HI: next_answer.rdata[7:0] = cap[0][15:8];
			IDX_CAP2_LO: next_answer.rdata[7:0] = cap[1][7:0];
			IDX_CAP2_HI: next_answer.rdata[7:0] = cap[1][15:8];
			IDX_DUTY1: next_answer.rdata[7:0] = duty_hi[0];
			IDX_DUTY2: next_answer.rdata[7:0] = duty_hi[1];
			IDX_PIN_CTRL: next_answer.rdata[7:0] = {2'h0, latch_a, 2'h0, dir};
			default: next_answer.err = 1'b1;
		endcase
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end
		else if (setup)
		begin
			PRDATA_O <= PWRITE_I ? 32'h0000_0000 : next_answer.rdata;
			PSLVERR_O <= next_answer.err;
		end
	end

	// ----------------------------------------------------------------
	// Control, duty and pin registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ctrl[0] <= CTRL_RESET;
			ctrl[1] <= CTRL_RESET;
			duty_hi[0] <= REG8_RESET;
			duty_hi[1] <= REG8_RESET;
			dir <= DIR_RESET;
			latch_a <= 2'h0;
			enable <= 2'h0;
		end
		else if (wr)
		begin
			unique case (idx)
				IDX_CTRL1: ctrl[0] <= PWDATA_I[5:0];
				IDX_CTRL2: ctrl[1] <= PWDATA_I[5:0];
				IDX_DUTY1: duty_hi[0] <= PWDATA_I[7:0];
				IDX_DUTY2: duty_hi[1] <= PWDATA_I[7:0];
				IDX_PIN_CTRL:
				begin
					dir <= PWDATA_I[DIR_BIT0+:2];
					latch_a <= PWDATA_I[LATCH_BIT0+:2];
				end
				IDX_ENABLE: enable[0] <= PWDATA_I[FLAG1_BIT];
				IDX_ENABLE2: enable[1] <= PWDATA_I[FLAG2_BIT];
				default: ;
			endcase
		end
	end

	assign DUTY1_O = {duty_hi[0], ctrl[0].duty_low};
	assign DUTY2_O = {duty_hi[1], ctrl[1].duty_low};

	// ----------------------------------------------------------------
	// Pin synchroniser: a change counts once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			s1 <= 2'h0;
			s2 <= 2'h0;
			s3 <= 2'h0;
			pin_lvl <= 2'h0;
		end
		else
		begin
			s1 <= CAP_PIN_I;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < 2; i++)
				if (s2[i] == s3[i])
					pin_lvl[i] <= s3[i];
		end
	end

	// Output pin: own latch level, or the compare level in modes 1000/1001, is what the edge logic sees
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			CAP_PIN_OE_O[i] = ~dir[i];
			CAP_PIN_O[i] = (ctrl[i].mode_select_field == MODE_CMP_SET ||
				ctrl[i].mode_select_field == MODE_CMP_CLR) ?
				cmp_lvl[i] : latch_a[i];
			eff_lvl[i] = dir[i] ? pin_lvl[i] : CAP_PIN_O[i];
		end
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_chan
		capture_event_unit u_evt (
			.clk_i(REF_CLK_I),
			.rst_i(RST_I),
			.level_i(eff_lvl[g]),
			.mode_i(ctrl[g].mode_select_field),
			.event_o(cap_evt[g])
		);
	end

	// ----------------------------------------------------------------
	// Capture pair; a capture beats a software write in the same cycle
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			cap[0] <= 16'h0000;
			cap[1] <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (cap_evt[i])
					cap[i] <= TIMER_I;
				else if (wr && idx == (i == 0 ? IDX_CAP1_LO : IDX_CAP2_LO))
					cap[i][7:0] <= PWDATA_I[7:0];
				else if (wr && idx == (i == 0 ? IDX_CAP1_HI : IDX_CAP2_HI))
					cap[i][15:8] <= PWDATA_I[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Compare match, one hit per match run
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			cmp_hit[i] = is_compare(ctrl[i].mode_select_field) &&
				TIMER_I == cap[i] && !match_q[i];
			false_evt[i] = wr &&
				idx == (i == 0 ? IDX_CTRL1 : IDX_CTRL2) &&
				is_capture(ctrl[i].mode_select_field) &&
				is_capture(PWDATA_I[3:0]) &&
				PWDATA_I[3:0] != ctrl[i].mode_select_field;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			match_q <= 2'h0;
			cmp_lvl <= 2'h0;
			TIMER_RESET_O <= 1'b0;
		end
		else
		begin
			TIMER_RESET_O <= 1'b0;
			for (int i = 0; i < 2; i++)
			begin
				match_q[i] <= is_compare(ctrl[i].mode_select_field) &&
					TIMER_I == cap[i];
				if (ctrl[i].mode_select_field == MODE_OFF)
					cmp_lvl[i] <= 1'b0;
				else if (cmp_hit[i])
				begin
					if (ctrl[i].mode_select_field == MODE_CMP_SET)
						cmp_lvl[i] <= 1'b1;
					else if (ctrl[i].mode_select_field == MODE_CMP_CLR)
						cmp_lvl[i] <= 1'b0;
					if (ctrl[i].mode_select_field == MODE_CMP_SPECIAL)
						TIMER_RESET_O <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Request flags: write one to clear, a new event wins over the clear
	// ----------------------------------------------------------------
	assign flag_clr[0] = wr && idx == IDX_FLAG && PWDATA_I[FLAG1_BIT];
	assign flag_clr[1] = wr && idx == IDX_FLAG2 && PWDATA_I[FLAG2_BIT];

	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			flag <= 2'h0;
		else
			flag <= (flag & ~flag_clr) | cap_evt | cmp_hit |
				false_evt;
	end

	assign IRQ_O = |(flag & enable);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	property p_ctrl_upper_zero;
		setup && !PWRITE_I && (idx == IDX_CTRL1 || idx == IDX_CTRL2)
			|=> PRDATA_O[7:6] == 2'h0;
	endproperty
	a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
		else $error("control upper bits not zero");

	property p_duty_low;
		wr && idx == IDX_CTRL1 |=> DUTY1_O[1:0] == $past(PWDATA_I[5:4]);
	endproperty
	a_duty_low: assert property (p_duty_low)
		else $error("duty low bits wrong");

	property p_capture_value;
		cap_evt[0] |=> cap[0] == $past(TIMER_I);
	endproperty
	a_capture_value: assert property (p_capture_value)
		else $error("capture value wrong");

	property p_rise_event;
		ctrl[1].mode_select_field == MODE_CAP_RISE && $rose(eff_lvl[1])
			|-> ##1 (ctrl[1].mode_select_field != MODE_CAP_RISE || flag[1]);
	endproperty
	a_rise_event: assert property (p_rise_event)
		else $error("rising edge not captured");

	property p_flag_sticky;
		flag[0] && !flag_clr[0] |=> flag[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without clear");

	property p_flag_set;
		cap_evt[0] |=> flag[0] && IRQ_O == enable[0];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("capture did not set flag");

	property p_overwrite;
		cap_evt[1] && flag[1] |=> cap[1] == $past(TIMER_I);
	endproperty
	a_overwrite: assert property (p_overwrite)
		else $error("second capture lost");

	property p_latch_capture;
		!dir[0] && ctrl[0].mode_select_field == MODE_CAP_RISE &&
			$rose(CAP_PIN_O[0]) |-> ##[0:1] cap_evt[0] ##1 flag[0];
	endproperty
	a_latch_capture: assert property (p_latch_capture)
		else $error("latch write did not capture");

	property p_special;
		cmp_hit[0] && ctrl[0].mode_select_field == MODE_CMP_SPECIAL
			|=> TIMER_RESET_O ##1 !TIMER_RESET_O;
	endproperty
	a_special: assert property (p_special)
		else $error("special event missed timer reset");

	property p_off_quiet;
		ctrl[0].mode_select_field == MODE_OFF |-> !cap_evt[0] && !cmp_hit[0];
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("event while channel off");

	c_capture: cover property (cap_evt[0] ##1 flag[0] && IRQ_O);
	c_compare: cover property (cmp_hit[1] && !flag[1]);
	c_clear: cover property (flag[0] ##1 flag_clr[0] ##1 !flag[0]);
	c_false: cover property (false_evt[0]);

endmodule // capcmp_ctrl

//--- bench/pin_source.sv
// Far-side model: external source driving the two capture pins
`timescale 1ns/1ps
module pin_source
#(
	parameter int LAG = 1
)
(
	input wire logic clk_i,
	input wire logic [1:0] want_i,
	output logic [1:0] pin_o
);
	int cnt;

	initial pin_o = 2'b00;
	initial cnt = 0;

	// Level follows a request LAG+1 cycles late, so a slow source can be
	// modelled; the bench spaces edges well past the pin filter
	always @(posedge clk_i)
	begin
		if (want_i == pin_o)
			cnt <= 0;
		else if (cnt >= LAG)
		begin
			pin_o <= want_i;
			cnt <= 0;
		end
		else
			cnt <= cnt + 1;
	end
endmodule // pin_source

//--- bench/testbench.sv
// Self-checking bench for the capture/compare/PWM control block
`timescale 1ns/1ps
module testbench;
	import capcmp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [15:0] timer = 16'h0000;
	logic [1:0] want = 2'b00;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, tmr_rst, irq, err;
	logic [1:0] src, pin, pin_o, pin_oe;
	logic [9:0] duty1, duty2;
	logic [1:0] pulse_sel = 2'b01;
	int bad_count = 0;
	int checks = 0;
	int trst_seen = 0;
	int need[4] = '{1, 1, 4, 16};
	// Latch stays 1: after the clear, 1010 and 1011 must show the latch
	logic [3:0] cmp_mode[4] = '{MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_SWI,
		MODE_CMP_SPECIAL};
	logic cmp_lvl[4] = '{1'b1, 1'b0, 1'b1, 1'b1};

	always #50 clk = ~clk;
	// Pin level resolved from the device enable and the source
	assign pin = (pin_oe & pin_o) | (~pin_oe & src);
	always @(posedge clk)
		if (tmr_rst === 1'b1)
			trst_seen <= trst_seen + 1;

	pin_source #(.LAG(1)) src_model (.clk_i(clk), .want_i(want),
		.pin_o(src));

	capcmp_ctrl uut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .TIMER_I(timer), .CAP_PIN_I(pin),
		.CAP_PIN_O(pin_o), .CAP_PIN_OE_O(pin_oe),
		.TIMER_RESET_O(tmr_rst), .DUTY1_O(duty1), .DUTY2_O(duty2),
		.IRQ_O(irq));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			$display("MISMATCH %0t bus wait ran out", $time);
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rchk(input logic [9:0] idx, input logic [31:0] exp,
		input string what);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd, exp, what);
		chk(32'(err), 32'h0000_0000, "slverr");
	endtask

	// Edges spaced beyond the synchroniser and capture latency
	task automatic pulse;
		want <= pulse_sel;
		repeat (8) @(posedge clk);
		want <= 2'b00;
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rchk(IDX_FLAG, 32'h0000_0000, "flag reset");
		rchk(IDX_ENABLE, 32'h0000_0000, "enable reset");
		rchk(IDX_CTRL1, 32'h0000_0000, "ctrl1 reset");
		rchk(IDX_PIN_CTRL, 32'h0000_0003, "dir reset");
		apb(1'b1, IDX_DUTY1, 32'h0000_00a5);
		apb(1'b1, IDX_CTRL1, 32'h0000_00ff);
		rchk(IDX_CTRL1, 32'h0000_003f, "ctrl upper");
		chk(32'(duty1), 32'h0000_0297, "duty");
		apb(1'b1, 10'h3ff, 32'h0000_00ff);
		apb(1'b0, 10'h3ff, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped data");
		chk(32'(err), 32'h0000_0001, "unmapped err");
		apb(1'b1, IDX_ENABLE, 32'h0000_0004);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, IDX_CTRL1, 32'(MODE_OFF));
			apb(1'b1, IDX_CTRL1, 32'(MODE_CAP_FALL) + m);
			apb(1'b1, IDX_FLAG, 32'h0000_0004);
			for (int k = 1; k < need[m]; k++)
				pulse();
			rchk(IDX_FLAG, 32'h0000_0000, "early capture");
			timer <= 16'h1230 + 16'(m);
			pulse();
			chk(32'(irq), 32'h0000_0001, "irq");
			rchk(IDX_FLAG, 32'h0000_0004, "flag");
			rchk(IDX_CAP1_LO, 32'h0000_0030 + m, "cap lo");
			rchk(IDX_CAP1_HI, 32'h0000_0012, "cap hi");
		end
		apb(1'b1, IDX_CTRL1, 32'(MODE_OFF));
		apb(1'b1, IDX_CTRL1, 32'(MODE_CAP_RISE));
		apb(1'b1, IDX_FLAG, 32'h0000_0004);
		timer <= 16'hbeef;
		pulse();
		timer <= 16'h5a5a;
		pulse();
		rchk(IDX_CAP1_LO, 32'h0000_005a, "overwrite lo");
		rchk(IDX_CAP1_HI, 32'h0000_005a, "overwrite hi");
		apb(1'b1, IDX_ENABLE, 32'h0000_0000);
		rchk(IDX_FLAG, 32'h0000_0004, "flag held");
		chk(32'(irq), 32'h0000_0000, "masked irq");
		apb(1'b1, IDX_FLAG, 32'h0000_0004);
		rchk(IDX_FLAG, 32'h0000_0000, "flag clear");
		apb(1'b1, IDX_CTRL1, 32'(MODE_CAP_FALL));
		rchk(IDX_FLAG, 32'h0000_0004, "false flag");
		apb(1'b1, IDX_CTRL1, 32'(MODE_CAP_RISE));
		apb(1'b1, IDX_PIN_CTRL, 32'h0000_0002);
		apb(1'b1, IDX_FLAG, 32'h0000_0004);
		chk(32'(pin_oe[0]), 32'h0000_0001, "pin oe");
		apb(1'b1, IDX_PIN_CTRL, 32'h0000_0012);
		repeat (4) @(posedge clk);
		rchk(IDX_FLAG, 32'h0000_0004, "latch capture");
		apb(1'b1, IDX_CAP1_LO, 32'h0000_0050);
		apb(1'b1, IDX_CAP1_HI, 32'h0000_0000);
		timer <= 16'h0000;
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, IDX_CTRL1, 32'(cmp_mode[m]));
			apb(1'b1, IDX_FLAG, 32'h0000_0004);
			timer <= 16'h0050;
			repeat (3) @(posedge clk);
			timer <= 16'h0000;
			rchk(IDX_FLAG, 32'h0000_0004, "match flag");
			chk(32'(pin_o[0]), 32'(cmp_lvl[m]), "match pin");
		end
		chk(32'(trst_seen), 32'h0000_0001, "timer reset");
		// Second channel: duty, rising capture, overwrite, own flag
		apb(1'b1, IDX_DUTY2, 32'h0000_003c);
		apb(1'b1, IDX_CTRL2, 32'h0000_0025);
		apb(1'b1, IDX_ENABLE2, 32'h0000_0001);
		chk(32'(duty2), 32'h0000_00f2, "duty2");
		apb(1'b1, IDX_FLAG2, 32'h0000_0001);
		pulse_sel = 2'b10;
		timer <= 16'h4321;
		pulse();
		timer <= 16'h8765;
		pulse();
		rchk(IDX_CAP2_LO, 32'h0000_0065, "cap2 lo");
		rchk(IDX_CAP2_HI, 32'h0000_0087, "cap2 hi");
		rchk(IDX_FLAG2, 32'h0000_0001, "flag2");
		chk(32'(irq), 32'h0000_0001, "irq2");
		print_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("MISMATCH %0t run limit reached", $time);
		print_verdict();
	end
endmodule // testbench
